// ===== design/rtexec_pkg.sv
// Opcode encodings and register widths for the register transfer executor
package rtexec_pkg;
  localparam logic [9:0] OP_WRITE_IRQ_ONE    = 10'h03e;
  localparam logic [9:0] OP_WRITE_IRQ_TWO    = 10'h03f;
  localparam logic [9:0] OP_WRITE_TMR_ONE    = 10'h20e;
  localparam logic [9:0] OP_WRITE_TMR_TWO    = 10'h20f;
  localparam logic [9:0] OP_WRITE_TMR_THREE  = 10'h290;
  localparam logic [9:0] OP_WRITE_TMR_FOUR   = 10'h291;
  localparam logic [9:0] OP_ACC_TO_COL       = 10'h00c;
  localparam logic [9:0] OP_COL_TO_ACC       = 10'h01f;
  localparam logic [9:0] OP_SEC_TO_ACC       = 10'h01e;
  localparam logic [9:0] OP_ACC_TO_SEC       = 10'h00e;
  localparam logic [9:0] OP_PACK             = 10'h01a;
  localparam logic [9:0] OP_UNPACK           = 10'h02a;
  localparam logic [9:0] OP_ACC_TO_PAGE      = 10'h029;
  localparam logic [9:0] OP_PAGE_TO_ACC      = 10'h051;
  localparam logic [9:0] OP_BANK_TO_ACC      = 10'h053;
  localparam logic [9:0] OP_FILE_TO_ACC      = 10'h052;
  localparam logic [9:0] OP_SP_TO_ACC        = 10'h050;
  localparam logic [9:0] OP_COL_INC          = 10'h013;
  localparam logic [9:0] OP_COL_DEC          = 10'h017;
  localparam logic [9:0] OP_WDOG_RESTART     = 10'h2a0;
  localparam logic [5:0] OP_XCHG_BASE        = 6'h2d;
  localparam logic [5:0] OP_XCHG_DEC_BASE    = 6'h2f;
  localparam logic [5:0] OP_XCHG_INC_BASE    = 6'h2e;
  localparam logic [1:0] OP_LOAD_FC_TOP      = 2'h3;
  localparam logic [7:0] OP_LOAD_BANK_BASE   = 8'h12;
  localparam logic [3:0] NIB_RESET           = 4'h0;
  localparam logic [3:0] NIB_ALL_ONES        = 4'hf;
  localparam logic [3:0] NIB_ONE             = 4'h1;
  localparam logic [7:0] BYTE_RESET          = 8'h00;
  localparam logic [2:0] TRI_RESET           = 3'h0;
  localparam logic [1:0] BANK_RESET          = 2'h0;
  typedef enum logic [1:0] {
    RTEXEC_XCHG_PLAIN = 2'b00,
    RTEXEC_XCHG_INC   = 2'b01,
    RTEXEC_XCHG_DEC   = 2'b10
  } rtexec_xchg_t;
endpackage : rtexec_pkg

// ===== design/rtexec_colstep.sv
// Column pointer stepper with wrap detection
`timescale 1ns/1ps
module rtexec_colstep
  import rtexec_pkg::*;
(
  input  wire logic [3:0] col,
  input  wire logic       inc,
  input  wire logic       dec,
  output logic      [3:0] col_next,
  output logic            wrapped
);
  always_comb begin
    col_next = col;
    wrapped  = 1'b0;
    if (inc) begin
      col_next = col + NIB_ONE;
      wrapped  = (col_next == NIB_RESET);
    end else if (dec) begin
      col_next = col - NIB_ONE;
      wrapped  = (col_next == NIB_ALL_ONES);
    end
  end
endmodule : rtexec_colstep

// ===== design/rtexec_core.sv
// Register transfer, exchange and watchdog-test instruction executor
`timescale 1ns/1ps
module rtexec_core
  import rtexec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       instr_valid,
  input  wire logic [9:0] instr,
  input  wire logic [3:0] mem_rdata,
  input  wire logic [2:0] sp_value,
  input  wire logic       watchdog_flag_one,
  output logic            watchdog_flag_clear,
  output logic            mem_we,
  output logic      [3:0] mem_wdata,
  output logic            skip_next,
  output logic      [3:0] acc_q,
  output logic      [3:0] sec_acc_q,
  output logic      [3:0] column_ptr_q,
  output logic      [3:0] file_ptr_q,
  output logic      [1:0] bank_sel_q,
  output logic      [2:0] page_q,
  output logic      [7:0] combined_q,
  output logic      [3:0] irq_ctrl_reg_one_q,
  output logic      [3:0] irq_ctrl_reg_two_q,
  output logic      [3:0] timer_ctrl_reg_one_q,
  output logic      [3:0] timer_ctrl_reg_two_q,
  output logic      [3:0] timer_ctrl_reg_three_q,
  output logic      [3:0] timer_ctrl_reg_four_q
);
  logic [3:0] imm;
  logic       is_xchg;
  logic       is_xinc;
  logic       is_xdec;
  logic       is_load_fc;
  logic       is_load_bank;
  logic       col_inc;
  logic       col_dec;
  logic [3:0] col_next;
  logic       col_wrap;
  logic       prev_load_fc_q;
  logic       suppress;
  logic       exec;

  assign imm          = instr[3:0];
  assign is_xchg      = (instr[9:4] == OP_XCHG_BASE);
  assign is_xinc      = (instr[9:4] == OP_XCHG_INC_BASE);
  assign is_xdec      = (instr[9:4] == OP_XCHG_DEC_BASE);
  assign is_load_fc   = (instr[9:8] == OP_LOAD_FC_TOP);
  assign is_load_bank = (instr[9:2] == OP_LOAD_BANK_BASE);
  // A repeated load in a run is dropped, not executed
  assign suppress     = is_load_fc && prev_load_fc_q;
  assign exec         = instr_valid && !suppress;
  assign col_inc      = exec && (is_xinc || instr == OP_COL_INC);
  assign col_dec      = exec && (is_xdec || instr == OP_COL_DEC);

  rtexec_colstep u_colstep (
    .col      (column_ptr_q),
    .inc      (col_inc),
    .dec      (col_dec),
    .col_next (col_next),
    .wrapped  (col_wrap)
  );

  // Skip is combinational so the sequencer sees it in the executing cycle
  always_comb begin
    skip_next = 1'b0;
    if (instr_valid && suppress) begin
      skip_next = 1'b0;
    end else if (exec && instr == OP_WDOG_RESTART) begin
      skip_next = watchdog_flag_one;
    end else if (col_inc || col_dec) begin
      skip_next = col_wrap;
    end
  end

  assign watchdog_flag_clear = exec && (instr == OP_WDOG_RESTART);
  assign mem_we    = exec && (is_xchg || is_xinc || is_xdec);
  assign mem_wdata = acc_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_load_fc_q <= 1'b0;
    end else if (instr_valid) begin
      prev_load_fc_q <= is_load_fc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= NIB_RESET;
    end else if (exec) begin
      if (is_xchg || is_xinc || is_xdec) begin
        acc_q <= mem_rdata;
      end else if (instr == OP_COL_TO_ACC) begin
        acc_q <= column_ptr_q;
      end else if (instr == OP_SEC_TO_ACC) begin
        acc_q <= sec_acc_q;
      end else if (instr == OP_FILE_TO_ACC) begin
        acc_q <= file_ptr_q;
      end else if (instr == OP_PAGE_TO_ACC) begin
        acc_q <= {1'b0, page_q};
      end else if (instr == OP_SP_TO_ACC) begin
        acc_q <= {1'b0, sp_value};
      end else if (instr == OP_BANK_TO_ACC) begin
        acc_q <= {2'b00, bank_sel_q};
      end else if (instr == OP_UNPACK) begin
        acc_q <= combined_q[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_acc_q  <= NIB_RESET;
      combined_q <= BYTE_RESET;
      page_q     <= TRI_RESET;
      bank_sel_q <= BANK_RESET;
    end else if (exec) begin
      if (instr == OP_ACC_TO_SEC) begin
        sec_acc_q <= acc_q;
      end else if (instr == OP_UNPACK) begin
        sec_acc_q <= combined_q[7:4];
      end
      if (instr == OP_PACK) begin
        combined_q <= {sec_acc_q, acc_q};
      end
      if (instr == OP_ACC_TO_PAGE) begin
        page_q <= acc_q[2:0];
      end
      if (is_load_bank) begin
        bank_sel_q <= instr[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      column_ptr_q <= NIB_RESET;
      file_ptr_q   <= NIB_RESET;
    end else if (exec) begin
      if (is_load_fc) begin
        file_ptr_q   <= instr[7:4];
        column_ptr_q <= instr[3:0];
      end else begin
        if (instr == OP_ACC_TO_COL) begin
          column_ptr_q <= acc_q;
        end else if (col_inc || col_dec) begin
          column_ptr_q <= col_next;
        end
        if (is_xchg || is_xinc || is_xdec) begin
          file_ptr_q <= file_ptr_q ^ imm;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ctrl_reg_one_q <= NIB_RESET;
      irq_ctrl_reg_two_q <= NIB_RESET;
    end else if (exec) begin
      if (instr == OP_WRITE_IRQ_ONE) begin
        irq_ctrl_reg_one_q <= acc_q;
      end
      if (instr == OP_WRITE_IRQ_TWO) begin
        irq_ctrl_reg_two_q <= acc_q;
      end
    end
  end

  // Timer writes decoded separately; the second accumulator move shares no code with them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_ctrl_reg_one_q   <= NIB_RESET;
      timer_ctrl_reg_two_q   <= NIB_RESET;
      timer_ctrl_reg_three_q <= NIB_RESET;
      timer_ctrl_reg_four_q  <= NIB_RESET;
    end else if (exec) begin
      if (instr == OP_WRITE_TMR_ONE) begin
        timer_ctrl_reg_one_q <= acc_q;
      end
      if (instr == OP_WRITE_TMR_TWO) begin
        timer_ctrl_reg_two_q <= acc_q;
      end
      if (instr == OP_WRITE_TMR_THREE) begin
        timer_ctrl_reg_three_q <= acc_q;
      end
      if (instr == OP_WRITE_TMR_FOUR) begin
        timer_ctrl_reg_four_q <= acc_q;
      end
    end
  end

  irq_one_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_WRITE_IRQ_ONE |=> irq_ctrl_reg_one_q == $past(acc_q))
    else $error("irq one write wrong");
  tmr_four_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_WRITE_TMR_FOUR |=> timer_ctrl_reg_four_q == $past(acc_q))
    else $error("timer four write wrong");
  acc_to_col_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_ACC_TO_COL |-> !skip_next ##1 column_ptr_q == $past(acc_q))
    else $error("column move wrong");
  wdog_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_WDOG_RESTART |-> skip_next == watchdog_flag_one && watchdog_flag_clear)
    else $error("watchdog test wrong");
  sequence xchg_issue_s;
    exec && (is_xchg || is_xinc || is_xdec);
  endsequence
  xchg_swap_a: assert property (@(posedge clk) disable iff (!rst_n)
    xchg_issue_s |-> mem_we && mem_wdata == acc_q ##1
      acc_q == $past(mem_rdata) && file_ptr_q == ($past(file_ptr_q) ^ $past(imm)))
    else $error("exchange wrong");
  xinc_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && is_xinc |-> skip_next == (column_ptr_q == NIB_ALL_ONES))
    else $error("increment skip wrong");
  xdec_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && is_xdec |-> skip_next == (column_ptr_q == NIB_RESET))
    else $error("decrement skip wrong");
  pack_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_PACK |=> combined_q == {$past(sec_acc_q), $past(acc_q)})
    else $error("pack wrong");
  load_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    instr_valid && is_load_fc ##1 instr_valid && is_load_fc |=> $stable(column_ptr_q))
    else $error("repeated load executed");
  bank_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_BANK_TO_ACC |=> acc_q[3:2] == 2'b00)
    else $error("bank read not zero filled");
  page_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_PAGE_TO_ACC |=> acc_q[3] == 1'b0)
    else $error("page read not zero filled");
  col_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && instr == OP_COL_INC |-> skip_next == (column_ptr_q == NIB_ALL_ONES))
    else $error("column increment skip wrong");
endmodule : rtexec_core

// ===== verification/rtexec_core_tb.sv
// Self-checking testbench for the register transfer executor
`timescale 1ns/1ps
module rtexec_core_tb
  import rtexec_pkg::*;
();
  logic       clk, rst_n, instr_valid, watchdog_flag_one;
  logic [9:0] instr;
  logic [3:0] mem_rdata, mem_wdata, acc_q, sec_acc_q, column_ptr_q, file_ptr_q;
  logic [2:0] sp_value, page_q;
  logic       watchdog_flag_clear, mem_we, skip_next;
  logic [1:0] bank_sel_q;
  logic [7:0] combined_q;
  logic [3:0] irq_ctrl_reg_one_q, irq_ctrl_reg_two_q, timer_ctrl_reg_one_q;
  logic [3:0] timer_ctrl_reg_two_q, timer_ctrl_reg_three_q, timer_ctrl_reg_four_q;
  logic [3:0] m_acc, m_sec, m_col, m_file, m_irq1, m_irq2, m_tm1, m_tm2, m_tm3, m_tm4;
  logic [1:0] m_bank;
  logic [2:0] m_page;
  logic [7:0] m_comb;
  logic       m_lx;
  int         err_total, checked;
  logic [9:0] ops [26] = '{OP_WRITE_IRQ_ONE, OP_WRITE_IRQ_TWO, OP_WRITE_TMR_ONE, OP_WRITE_TMR_TWO,
    OP_WRITE_TMR_THREE, OP_WRITE_TMR_FOUR, OP_ACC_TO_COL, OP_COL_TO_ACC, OP_SEC_TO_ACC, OP_PACK,
    OP_UNPACK, OP_ACC_TO_PAGE, OP_PAGE_TO_ACC, OP_BANK_TO_ACC, OP_FILE_TO_ACC, OP_SP_TO_ACC,
    OP_COL_INC, OP_COL_DEC, OP_WDOG_RESTART, 10'h2d0, 10'h2e0, 10'h2f0, 10'h300, 10'h048, 10'h000,
    OP_ACC_TO_SEC};

  rtexec_core dut (.clk, .rst_n, .instr_valid, .instr, .mem_rdata, .sp_value, .watchdog_flag_one,
    .watchdog_flag_clear, .mem_we, .mem_wdata, .skip_next, .acc_q, .sec_acc_q, .column_ptr_q,
    .file_ptr_q, .bank_sel_q, .page_q, .combined_q, .irq_ctrl_reg_one_q, .irq_ctrl_reg_two_q,
    .timer_ctrl_reg_one_q, .timer_ctrl_reg_two_q, .timer_ctrl_reg_three_q,
    .timer_ctrl_reg_four_q);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic fin(string nm);
    $display("test %s done: %0d checks, %0d mismatches", nm, checked, err_total);
  endtask : fin

  // Reference model: updates the expected state, returns the expected skip
  function automatic logic model(logic [9:0] op, logic [3:0] rd, logic wdf);
    logic sk;
    sk = 1'b0;
    if (op[9:8] == OP_LOAD_FC_TOP) begin
      if (!m_lx) begin
        m_file = op[7:4];
        m_col  = op[3:0];
      end
    end else if (op[9:4] inside {OP_XCHG_BASE, OP_XCHG_INC_BASE, OP_XCHG_DEC_BASE}) begin
      m_file = m_file ^ op[3:0];
      m_acc  = rd;
      if (op[9:4] == OP_XCHG_INC_BASE) begin
        m_col = m_col + 4'h1;
        sk    = (m_col == 4'h0);
      end else if (op[9:4] == OP_XCHG_DEC_BASE) begin
        m_col = m_col - 4'h1;
        sk    = (m_col == 4'hf);
      end
    end else if (op[9:2] == OP_LOAD_BANK_BASE) begin
      m_bank = op[1:0];
    end else begin
      case (op)
        OP_WRITE_IRQ_ONE:   m_irq1 = m_acc;
        OP_WRITE_IRQ_TWO:   m_irq2 = m_acc;
        OP_WRITE_TMR_ONE:   m_tm1 = m_acc;
        OP_WRITE_TMR_TWO:   m_tm2 = m_acc;
        OP_WRITE_TMR_THREE: m_tm3 = m_acc;
        OP_WRITE_TMR_FOUR:  m_tm4 = m_acc;
        OP_ACC_TO_COL:      m_col = m_acc;
        OP_COL_TO_ACC:      m_acc = m_col;
        OP_SEC_TO_ACC:      m_acc = m_sec;
        OP_ACC_TO_SEC:      m_sec = m_acc;
        OP_PACK:            m_comb = {m_sec, m_acc};
        OP_UNPACK:          {m_sec, m_acc} = m_comb;
        OP_ACC_TO_PAGE:     m_page = m_acc[2:0];
        OP_PAGE_TO_ACC:     m_acc = {1'b0, m_page};
        OP_BANK_TO_ACC:     m_acc = {2'b00, m_bank};
        OP_FILE_TO_ACC:     m_acc = m_file;
        OP_SP_TO_ACC:       m_acc = {1'b0, sp_value};
        OP_WDOG_RESTART:    sk = wdf;
        OP_COL_INC: begin
          m_col = m_col + 4'h1;
          sk    = (m_col == 4'h0);
        end
        OP_COL_DEC: begin
          m_col = m_col - 4'h1;
          sk    = (m_col == 4'hf);
        end
        default: sk = 1'b0;
      endcase
    end
    m_lx = (op[9:8] == OP_LOAD_FC_TOP);
    return sk;
  endfunction : model

  task automatic regs();
    chk("acc", 16'(acc_q), 16'(m_acc));
    chk("sec_acc", 16'(sec_acc_q), 16'(m_sec));
    chk("column", 16'(column_ptr_q), 16'(m_col));
    chk("file", 16'(file_ptr_q), 16'(m_file));
    chk("bank", 16'(bank_sel_q), 16'(m_bank));
    chk("page", 16'(page_q), 16'(m_page));
    chk("combined", 16'(combined_q), 16'(m_comb));
    chk("irq", 16'({irq_ctrl_reg_one_q, irq_ctrl_reg_two_q}), 16'({m_irq1, m_irq2}));
    chk("timer", {timer_ctrl_reg_one_q, timer_ctrl_reg_two_q, timer_ctrl_reg_three_q,
      timer_ctrl_reg_four_q}, {m_tm1, m_tm2, m_tm3, m_tm4});
  endtask : regs

  // Registers seen here hold the result of the previous instruction
  task automatic step(logic [9:0] op, logic [3:0] rd, logic wdf);
    logic sk;
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr = op;
    mem_rdata = rd;
    watchdog_flag_one = wdf;
    sp_value = 3'($urandom);
    #1;
    regs();
    chk("mem_wdata", 16'(mem_wdata), 16'(m_acc));
    chk("mem_we", 16'(mem_we), 16'(op[9:4] inside {OP_XCHG_BASE, OP_XCHG_INC_BASE,
      OP_XCHG_DEC_BASE}));
    chk("wdog_clear", 16'(watchdog_flag_clear), 16'(op == OP_WDOG_RESTART));
    sk = model(op, rd, wdf);
    chk("skip_next", 16'(skip_next), 16'(sk));
  endtask : step

  // An idle cycle shows an opcode that must not execute
  task automatic idle();
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    instr = OP_WRITE_IRQ_ONE;
    #1;
    regs();
  endtask : idle

  // Whole run is under a thousand cycles; this limit only catches a hang
  initial begin
    #50000;
    err_total++;
    test_done();
  end

  initial begin
    logic [9:0] op;
    logic [9:0] r;
    {rst_n, instr_valid, instr, mem_rdata, sp_value, watchdog_flag_one} = '0;
    {m_acc, m_sec, m_col, m_file, m_irq1, m_irq2, m_tm1, m_tm2, m_tm3, m_tm4} = '0;
    {m_bank, m_page, m_comb, m_lx} = '0;
    void'($urandom(39));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle();
    fin("reset");
    for (int i = 0; i < 6; i++) begin
      step(10'h2d0, 4'($urandom), 1'b0);
      step(ops[i], 4'h0, 1'b0);
    end
    fin("control writes");
    // Column wraps both ways, standalone and inside exchanges
    foreach (ops[i]) begin
      if (i >= 16 && i <= 17) step(ops[i], 4'h0, 1'b0);
    end
    step(10'h2f5, 4'h6, 1'b0);
    step(10'h2e9, 4'hc, 1'b0);
    step(10'h2e0, 4'h3, 1'b0);
    step(OP_COL_DEC, 4'h0, 1'b0);
    step(OP_COL_DEC, 4'h0, 1'b0);
    step(OP_COL_INC, 4'h0, 1'b0);
    for (int j = 0; j < 16; j++) step({OP_XCHG_BASE, 4'(j)}, 4'($urandom), 1'b0);
    fin("column and exchange");
    step(10'h2d0, 4'ha, 1'b0);
    step(OP_ACC_TO_SEC, 4'h0, 1'b0);
    for (int i = 6; i < 16; i++) step(ops[i], 4'($urandom), 1'b0);
    for (int z = 0; z < 4; z++) begin
      step({OP_LOAD_BANK_BASE, 2'(z)}, 4'h0, 1'b0);
      step(OP_BANK_TO_ACC, 4'h0, 1'b0);
    end
    fin("moves");
    step(OP_WDOG_RESTART, 4'h0, 1'b0);
    step(OP_WDOG_RESTART, 4'h0, 1'b1);
    fin("watchdog");
    step(10'h3a5, 4'h0, 1'b0);
    idle();
    step(10'h35c, 4'h0, 1'b0);
    step(10'h3ff, 4'h0, 1'b0);
    step(OP_FILE_TO_ACC, 4'h0, 1'b0);
    step(10'h312, 4'h0, 1'b0);
    step(OP_COL_TO_ACC, 4'h0, 1'b0);
    fin("load run");
    repeat (400) begin
      if ($urandom_range(0, 7) == 0) begin
        idle();
      end else begin
        op = ops[$urandom_range(0, 25)];
        r = 10'($urandom);
        if (op[9:8] == OP_LOAD_FC_TOP) op[7:0] = r[7:0];
        else if (op[9:6] == 4'hb) op[3:0] = r[3:0];
        else if (op[9:2] == OP_LOAD_BANK_BASE) op[1:0] = r[1:0];
        step(op, 4'($urandom), 1'($urandom));
      end
    end
    idle();
    fin("random");
    // Mid-run reset must clear every register and any load run in progress
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    {m_acc, m_sec, m_col, m_file, m_irq1, m_irq2, m_tm1, m_tm2, m_tm3, m_tm4} = '0;
    {m_bank, m_page, m_comb, m_lx} = '0;
    idle();
    step(10'h3c3, 4'h0, 1'b0);
    step(OP_COL_TO_ACC, 4'h0, 1'b0);
    idle();
    fin("reset again");
    test_done();
  end
endmodule : rtexec_core_tb
